/* verilog/smfmc_pkg.sv */
// Shared constants, table and types for the stepper fault and microstep link
`default_nettype none
package smfmc_pkg;
    // ------------------------------------------------------------
    // Command word layout
    // ------------------------------------------------------------
    localparam int WORD_BITS = 12;
    localparam int ENTRY_BITS = 6;
    localparam int PHASE_BITS = 6;
    localparam int DECAY_BIT = 5;
    localparam int MAG_MSB = 4;
    localparam int MAG_LSB = 1;
    localparam int SIGN_BIT = 0;
    localparam logic [5:0] QUAD_OFFSET = 6'h10;
    localparam logic [11:0] DECAY_BITS_MASK = 12'h820;
    localparam logic [5:0] PHASE_RST = 6'h00;
    localparam logic [3:0] MAG_ZERO = 4'h0;
    localparam logic [3:0] BITCNT_FULL = 4'hC;

    // ------------------------------------------------------------
    // Fault limits: error count in events, lockout and quiet times in PWM cycles
    // ------------------------------------------------------------
    localparam logic [1:0] ERR_LIMIT = 2'h3;
    localparam logic [5:0] LOCKOUT_CYCLES = 6'h3F;
    localparam logic [6:0] QUIET_LIMIT = 7'h40;

    // ------------------------------------------------------------
    // Link timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCLK_PERIOD_NS = 800;
    localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Controller register map and fields
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LAST = 8'h08;
    localparam logic [7:0] REG_SKIP = 8'h0C;
    localparam int CMD_GO = 0;
    localparam int CMD_CCW = 1;
    localparam int CMD_DECAY_LSB = 2;
    localparam int CMD_ZERO = 4;
    localparam int CMD_REDUCE = 5;
    localparam int CMD_MUTE_A = 6;
    localparam int CMD_MUTE_B = 7;
    localparam logic [1:0] DECAY_TABLE = 2'h0;
    localparam logic [1:0] DECAY_OFF = 2'h1;
    localparam logic [1:0] DECAY_ON = 2'h2;
    localparam int STAT_BUSY = 0;
    localparam int STAT_PREWARN = 1;
    localparam int STAT_PHASE_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Full-wave 64-entry sine table, magnitude shifted up, sign in bit 0
    // ------------------------------------------------------------
    localparam logic [5:0] SINE_TABLE [64] = '{
        6'h00, 6'h02, 6'h06, 6'h08, 6'h0C, 6'h0E, 6'h10, 6'h14,
        6'h16, 6'h18, 6'h18, 6'h1A, 6'h1C, 6'h1C, 6'h1E, 6'h1E,
        6'h3E, 6'h3E, 6'h3E, 6'h3C, 6'h3C, 6'h3A, 6'h38, 6'h38,
        6'h36, 6'h34, 6'h30, 6'h2E, 6'h2C, 6'h28, 6'h26, 6'h22,
        6'h01, 6'h03, 6'h07, 6'h09, 6'h0D, 6'h0F, 6'h11, 6'h15,
        6'h17, 6'h19, 6'h19, 6'h1B, 6'h1D, 6'h1D, 6'h1F, 6'h1F,
        6'h3F, 6'h3F, 6'h3F, 6'h3D, 6'h3D, 6'h3B, 6'h39, 6'h39,
        6'h37, 6'h35, 6'h31, 6'h2F, 6'h2D, 6'h29, 6'h27, 6'h23};

    typedef enum logic [2:0] {SPI_IDLE, SPI_LOW, SPI_HIGH, SPI_END, SPI_GAP} smfmc_spi_state_type;
endpackage
`default_nettype wire

/* verilog/smfmc_link_if.sv */
// Serial link between motion controller and bridge driver
`default_nettype none
interface smfmc_link_if;
    logic sclk;
    logic csn;
    logic mosi;
    modport ctrl (output sclk, output csn, output mosi);
    modport drv (input sclk, input csn, input mosi);
endinterface
`default_nettype wire

/* verilog/smfmc_driver.sv */
// Bridge driver end: word receiver, overcurrent counters and shutdown logic
//
// Function
// - Low-side trip ends cycle, bridge off.
// - Each overcurrent event adds one to counter.
// - Count three: bridge off 63 cycles, flag.
// - Over 63 quiet cycles clear counter.
// - Ignore trips while bridge blanking active.
// - High-side trip switches both bridges off.
// - High-side blanking is OR of both.
// - Disable or zero word clears flags.
// - Controller may clear flag early.
// - Controller isolates fault, one bridge on.
// - Overtemperature holds all transistors off.
// - Controller reduces current on pre-warning.
// - Disable input switches driver stage off.
// - Each accepted word is one microstep.
// - Word framed by chip select, MSB first.
// - Busy link: controller skips the step.
// - Table entry magnitude shifted, sign bit0.
// - Decay bit set where magnitude falls.
// - Word is entry[p] above entry[p+16].
// - Reverse decrements index, flips decay bits.
// - Decay bits may be forced off/on.
`default_nettype none
module smfmc_driver (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial link
    smfmc_link_if.drv link,
    // Chopper timing, same clock domain
    input wire logic pwm_cycle_start,
    input wire logic blank_a,
    input wire logic blank_b,
    // Analog comparators and pins, asynchronous
    input wire logic low_trip_a,
    input wire logic low_trip_b,
    input wire logic high_trip,
    input wire logic overtemp,
    input wire logic driver_disable_input,
    // Bridge control and status
    output logic bridge_off_a,
    output logic bridge_off_b,
    output logic err_flag_a,
    output logic err_flag_b,
    output logic err_flag_hs,
    output logic [5:0] coil_a_entry,
    output logic [5:0] coil_b_entry,
    output logic step_pulse
);
    import smfmc_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, filt_ff, nxt_filt;
    logic [NSYNC-1:0] agree;
    logic sclk_prev_ff, csn_prev_ff;

    assign async_in = {driver_disable_input, overtemp, high_trip, low_trip_b, low_trip_a,
                       link.mosi, link.csn, link.sclk};
    // A change counts once stages two and three agree
    assign agree = ~(s2_ff ^ s3_ff);
    assign nxt_filt = (s2_ff & agree) | (filt_ff & ~agree);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_ff <= 8'h06;
            s2_ff <= 8'h06;
            s3_ff <= 8'h06;
            filt_ff <= 8'h06;
            sclk_prev_ff <= 1'b0;
            csn_prev_ff <= 1'b1;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            filt_ff <= nxt_filt;
            sclk_prev_ff <= filt_ff[0];
            csn_prev_ff <= filt_ff[1];
        end
    end

    wire sclk_f = filt_ff[0];
    wire csn_f = filt_ff[1];
    wire mosi_f = filt_ff[2];
    wire [2:0] trip_f = filt_ff[5:3];
    wire ot_f = filt_ff[6];
    wire dis_f = filt_ff[7];

    // ------------------------------------------------------------
    // Word receiver
    // ------------------------------------------------------------
    logic [11:0] shift_ff, nxt_shift;
    logic [3:0] bitcnt_ff, nxt_bitcnt;
    logic zero_word_ff, nxt_zero_word;
    logic [5:0] coil_a_ff, coil_b_ff;
    logic step_ff;

    wire sclk_rise = sclk_f & ~sclk_prev_ff;
    wire csn_fall = ~csn_f & csn_prev_ff;
    wire csn_rise = csn_f & ~csn_prev_ff;
    // Frames shorter than twelve bits are dropped whole; bits past the twelfth are ignored
    wire word_ok = csn_rise & (bitcnt_ff == BITCNT_FULL);
    wire bit_take = sclk_rise & ~csn_f & (bitcnt_ff != BITCNT_FULL);
    wire zero_rx = (shift_ff[6+MAG_MSB:6+MAG_LSB] == MAG_ZERO) & (shift_ff[MAG_MSB:MAG_LSB] == MAG_ZERO);

    assign nxt_shift = bit_take ? {shift_ff[10:0], mosi_f} : shift_ff;
    assign nxt_bitcnt = csn_fall ? 4'h0 : (bit_take ? bitcnt_ff + 4'h1 : bitcnt_ff);
    assign nxt_zero_word = word_ok ? zero_rx : zero_word_ff;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_ff <= 12'h000;
            bitcnt_ff <= 4'h0;
            zero_word_ff <= 1'b1;
            coil_a_ff <= 6'h00;
            coil_b_ff <= 6'h00;
            step_ff <= 1'b0;
        end else begin
            shift_ff <= nxt_shift;
            bitcnt_ff <= nxt_bitcnt;
            zero_word_ff <= nxt_zero_word;
            coil_a_ff <= word_ok ? shift_ff[11:6] : coil_a_ff;
            coil_b_ff <= word_ok ? shift_ff[5:0] : coil_b_ff;
            step_ff <= word_ok;
        end
    end

    // ------------------------------------------------------------
    // Overcurrent channels: 0 bridge A, 1 bridge B, 2 high side
    // ------------------------------------------------------------
    // Disabled by pin or by an all-zero current word
    wire drv_en = ~dis_f & ~zero_word_ff;
    wire [2:0] blank_m = {blank_a | blank_b, blank_b, blank_a};
    logic [2:0] cyc_off_ff, lock_on, evt, flag_ff;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_chan
            logic [1:0] cnt_ff, nxt_cnt;
            logic [5:0] lock_ff, nxt_lock;
            logic [6:0] quiet_ff, nxt_quiet;
            logic nxt_cyc_off, nxt_flag;
            wire at_limit = (cnt_ff == ERR_LIMIT - 2'h1);
            wire quiet_done = pwm_cycle_start & (quiet_ff == QUIET_LIMIT - 7'h01);

            // Detection masked by blanking and by this channel's own cycle stop or lockout
            assign evt[gi] = trip_f[gi] & ~blank_m[gi] & ~cyc_off_ff[gi] & ~lock_on[gi];
            assign lock_on[gi] = (lock_ff != 6'h00);
            assign nxt_cyc_off = evt[gi] ? 1'b1 : (pwm_cycle_start ? 1'b0 : cyc_off_ff[gi]);
            // Event beats clear, so a trip during a clear is not lost
            assign nxt_cnt = evt[gi] ? (at_limit ? 2'h0 : cnt_ff + 2'h1) :
                             (~drv_en | quiet_done) ? 2'h0 : cnt_ff;
            assign nxt_lock = (evt[gi] & at_limit) ? LOCKOUT_CYCLES :
                              ~drv_en ? 6'h00 :
                              (pwm_cycle_start & lock_on[gi]) ? lock_ff - 6'h01 : lock_ff;
            assign nxt_flag = (evt[gi] & at_limit) ? 1'b1 : (~drv_en ? 1'b0 : flag_ff[gi]);
            assign nxt_quiet = (evt[gi] | ~drv_en) ? 7'h00 :
                               (pwm_cycle_start & (quiet_ff != QUIET_LIMIT)) ? quiet_ff + 7'h01 : quiet_ff;

            // Counters start clean
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    cnt_ff <= 2'h0;
                    lock_ff <= 6'h00;
                    quiet_ff <= 7'h00;
                    cyc_off_ff[gi] <= 1'b0;
                    flag_ff[gi] <= 1'b0;
                end else begin
                    cnt_ff <= nxt_cnt;
                    lock_ff <= nxt_lock;
                    quiet_ff <= nxt_quiet;
                    cyc_off_ff[gi] <= nxt_cyc_off;
                    flag_ff[gi] <= nxt_flag;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Bridge enables
    // ------------------------------------------------------------
    // High-side fault cannot be located, so it stops both bridges
    wire hs_stop = evt[2] | cyc_off_ff[2] | lock_on[2];
    wire all_stop = ~drv_en | ot_f;
    wire nxt_off_a = all_stop | hs_stop | evt[0] | cyc_off_ff[0] | lock_on[0];
    wire nxt_off_b = all_stop | hs_stop | evt[1] | cyc_off_ff[1] | lock_on[1];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bridge_off_a <= 1'b1;
            bridge_off_b <= 1'b1;
        end else begin
            bridge_off_a <= nxt_off_a;
            bridge_off_b <= nxt_off_b;
        end
    end

    assign err_flag_a = flag_ff[0];
    assign err_flag_b = flag_ff[1];
    assign err_flag_hs = flag_ff[2];
    assign coil_a_entry = coil_a_ff;
    assign coil_b_entry = coil_b_ff;
    assign step_pulse = step_ff;
endmodule
`default_nettype wire

/* verilog/smfmc_ctrl.sv */
// Motion controller end: AXI4-Lite registers, sine table stepping, serial sender
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`default_nettype none
module smfmc_ctrl #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // AXI4-Lite write
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Temperature pre-warning pin
    input wire logic prewarn_in,
    // Serial link
    smfmc_link_if.ctrl link
);
    import smfmc_pkg::*;

    // ------------------------------------------------------------
    // Write channel capture, address and data in either order
    // ------------------------------------------------------------
    logic aw_hold_ff, w_hold_ff, bvalid_ff;
    logic [ADDR_W-1:0] waddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff;
    logic [2:0] pw_sync_ff;
    logic prewarn_ff;

    assign awready = ~aw_hold_ff & ~bvalid_ff;
    assign wready = ~w_hold_ff & ~bvalid_ff;
    wire aw_take = awvalid & awready;
    wire w_take = wvalid & wready;
    wire wr_do = aw_hold_ff & w_hold_ff;
    wire [7:0] waddr8 = 8'(waddr_ff);
    wire w_mapped = (waddr_ff >> 4) == '0;
    wire wr_cmd = wr_do & w_mapped & (waddr8 == REG_CMD) & wstrb_ff[0];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            waddr_ff <= '0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            aw_hold_ff <= wr_do ? 1'b0 : (aw_take | aw_hold_ff);
            w_hold_ff <= wr_do ? 1'b0 : (w_take | w_hold_ff);
            waddr_ff <= aw_take ? awaddr : waddr_ff;
            wdata_ff <= w_take ? wdata : wdata_ff;
            wstrb_ff <= w_take ? wstrb : wstrb_ff;
            bvalid_ff <= wr_do ? 1'b1 : (bready ? 1'b0 : bvalid_ff);
            bresp_ff <= wr_do ? (w_mapped ? RESP_OKAY : RESP_SLVERR) : bresp_ff;
        end
    end

    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;

    // ------------------------------------------------------------
    // Step word builder
    // ------------------------------------------------------------
    logic [5:0] phase_ff;
    logic [11:0] last_ff;
    logic [15:0] skip_ff;
    smfmc_spi_state_type state_ff, nxt_state;
    wire busy = (state_ff != SPI_IDLE);

    wire ccw = wdata_ff[CMD_CCW];
    wire zero_cmd = wdata_ff[CMD_ZERO];
    wire [1:0] decay_mode = wdata_ff[CMD_DECAY_LSB+1:CMD_DECAY_LSB];
    wire [5:0] phase_step = ccw ? phase_ff - 6'h01 : phase_ff + 6'h01;
    // Six-bit index wraps modulo 64 by itself
    wire [5:0] entry_a = SINE_TABLE[phase_step];
    wire [5:0] entry_b = SINE_TABLE[6'(phase_step + QUAD_OFFSET)];
    wire [11:0] decay_reverse_mask = ccw ? DECAY_BITS_MASK : 12'h000;
    wire [11:0] raw_word = {entry_a, entry_b} ^ decay_reverse_mask;
    wire [11:0] decay_word = (decay_mode == DECAY_OFF) ? (raw_word & ~DECAY_BITS_MASK) :
                             (decay_mode == DECAY_ON) ? (raw_word | DECAY_BITS_MASK) : raw_word;
    // Pre-warning halves both magnitudes rather than waiting for shutdown
    wire reduce = wdata_ff[CMD_REDUCE] & prewarn_ff;
    wire [3:0] mag_a = reduce ? {1'b0, decay_word[6+MAG_MSB:6+MAG_LSB+1]} : decay_word[6+MAG_MSB:6+MAG_LSB];
    wire [3:0] mag_b = reduce ? {1'b0, decay_word[MAG_MSB:MAG_LSB+1]} : decay_word[MAG_MSB:MAG_LSB];
    // Muting one coil lets software find which bridge holds a high-side fault
    wire [3:0] mag_a_m = wdata_ff[CMD_MUTE_A] ? MAG_ZERO : mag_a;
    wire [3:0] mag_b_m = wdata_ff[CMD_MUTE_B] ? MAG_ZERO : mag_b;
    wire [11:0] step_word = {decay_word[11], mag_a_m, decay_word[6], decay_word[5], mag_b_m, decay_word[0]};
    // All-zero word disables the driver and clears its flags
    wire [11:0] send_word = zero_cmd ? 12'h000 : step_word;
    wire go = wr_cmd & wdata_ff[CMD_GO];
    wire start = go & ~busy;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_ff <= PHASE_RST;
            last_ff <= 12'h000;
            skip_ff <= 16'h0000;
            pw_sync_ff <= 3'h0;
            prewarn_ff <= 1'b0;
        end else begin
            phase_ff <= (start & ~zero_cmd) ? phase_step : phase_ff;
            last_ff <= start ? send_word : last_ff;
            skip_ff <= (go & busy) ? skip_ff + 16'h0001 : skip_ff;
            pw_sync_ff <= {pw_sync_ff[1:0], prewarn_in};
            prewarn_ff <= (pw_sync_ff[1] == pw_sync_ff[2]) ? pw_sync_ff[2] : prewarn_ff;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    assign arready = ~rvalid_ff;
    wire ar_take = arvalid & arready;
    wire [7:0] raddr8 = 8'(araddr);
    wire r_mapped = (araddr >> 4) == '0;
    wire [31:0] status_word = {18'h00000, phase_ff, 6'h00, prewarn_ff, busy};
    wire [31:0] rd_mux = (raddr8 == REG_STATUS) ? status_word :
                         (raddr8 == REG_LAST) ? {20'h00000, last_ff} :
                         (raddr8 == REG_SKIP) ? {16'h0000, skip_ff} :
                         (raddr8 == REG_CMD) ? {24'h000000, wdata_ff[7:1], 1'b0} : 32'h00000000;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= RESP_OKAY;
        end else begin
            rvalid_ff <= ar_take ? 1'b1 : (rready ? 1'b0 : rvalid_ff);
            rdata_ff <= ar_take ? (r_mapped ? rd_mux : 32'h00000000) : rdata_ff;
            rresp_ff <= ar_take ? (r_mapped ? RESP_OKAY : RESP_SLVERR) : rresp_ff;
        end
    end

    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;

    // ------------------------------------------------------------
    // Serial sender, clock made by dividing clk
    // ------------------------------------------------------------
    logic [7:0] tmr_ff;
    logic [3:0] bit_ff;
    logic [11:0] tx_ff;
    logic sclk_ff, csn_ff, mosi_ff;
    wire tmr_zero = (tmr_ff == 8'h00);
    wire last_bit = (bit_ff == 4'(WORD_BITS - 1));
    localparam logic [7:0] HALF_RELOAD = 8'(SCLK_HALF_CYC - 1);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            SPI_IDLE: nxt_state = start ? SPI_LOW : SPI_IDLE;
            SPI_LOW: nxt_state = tmr_zero ? SPI_HIGH : SPI_LOW;
            SPI_HIGH: nxt_state = tmr_zero ? (last_bit ? SPI_END : SPI_LOW) : SPI_HIGH;
            SPI_END: nxt_state = tmr_zero ? SPI_GAP : SPI_END;
            SPI_GAP: nxt_state = tmr_zero ? SPI_IDLE : SPI_GAP;
            default: nxt_state = SPI_IDLE;
        endcase
    end

    // Chip select frames the word, data moves MSB first on the low phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= SPI_IDLE;
            tmr_ff <= 8'h00;
            bit_ff <= 4'h0;
            tx_ff <= 12'h000;
            sclk_ff <= 1'b0;
            csn_ff <= 1'b1;
            mosi_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            tmr_ff <= (nxt_state != state_ff) ? HALF_RELOAD : (tmr_zero ? tmr_ff : tmr_ff - 8'h01);
            bit_ff <= start ? 4'h0 : ((state_ff == SPI_HIGH) & tmr_zero ? bit_ff + 4'h1 : bit_ff);
            tx_ff <= start ? send_word : ((state_ff == SPI_HIGH) & tmr_zero ? {tx_ff[10:0], 1'b0} : tx_ff);
            sclk_ff <= (nxt_state == SPI_HIGH);
            csn_ff <= (nxt_state == SPI_IDLE) | (nxt_state == SPI_GAP);
            mosi_ff <= start ? send_word[11] :
                       ((state_ff == SPI_HIGH) & tmr_zero ? tx_ff[10] : mosi_ff);
        end
    end

    assign link.sclk = sclk_ff;
    assign link.csn = csn_ff;
    assign link.mosi = mosi_ff;
endmodule
`default_nettype wire

/* dv/smfmc_asserts.sv */
// Checker for link framing and driver shutdown
`default_nettype none
module smfmc_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Link and driver pins
    input wire logic sclk,
    input wire logic csn,
    input wire logic mosi,
    input wire logic overtemp,
    input wire logic driver_disable_input,
    input wire logic bridge_off_a,
    input wire logic bridge_off_b,
    input wire logic step_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Twelve bits of eight clocks plus the trailing hold
    sequence frame_close;
        ##[96:104] $rose(csn);
    endsequence
    // Link framing
    a_sclk_idle_low: assert property (csn |-> !sclk) else $error("sclk outside frame");
    a_rise_in_frame: assert property ($rose(sclk) |-> !csn) else $error("sclk rise without select");
    a_mosi_steady_high: assert property (sclk && $past(sclk) |-> $stable(mosi)) else $error("mosi moved");
    a_sclk_half_len: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk) else $error("sclk half wrong");
    a_frame_full_len: assert property ($fell(csn) |-> frame_close) else $error("frame length wrong");
    // One microstep per frame
    a_step_after_frame: assert property ($rose(csn) |-> ##[1:8] step_pulse) else $error("no step");
    a_step_one_cycle: assert property (step_pulse |=> !step_pulse) else $error("step too long");
    // Shutdown inputs, past the synchroniser
    a_hot_all_off: assert property (overtemp [*8] |-> bridge_off_a && bridge_off_b) else $error("hot on");
    a_disable_all_off: assert property (driver_disable_input [*8] |-> bridge_off_a && bridge_off_b)
        else $error("disabled bridge on");
endmodule
`default_nettype wire

/* dv/stepper_fault_and_microstep_control_tb.sv */
// Bench joining controller and driver across the serial link
`default_nettype none
module stepper_fault_and_microstep_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import smfmc_pkg::*;
    logic clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rr;
    logic pwm_cycle_start, low_trip_a, overtemp, driver_disable_input, err_flag_a, err_flag_b, err_flag_hs;
    logic bridge_off_a, bridge_off_b, step_pulse, high_trip;
    logic [5:0] coil_a_entry, coil_b_entry, phase;
    logic [2:0] pwm_cnt;
    logic [11:0] w;
    logic [11:0] exp_q[$];
    int err_total = 0, total_checks = 0, seed = 91;
    smfmc_link_if link ();
    smfmc_ctrl u_smfmc_ctrl (.clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .prewarn_in(overtemp), .link(link));
    smfmc_driver u_smfmc_driver (.clk, .resetn, .link(link), .pwm_cycle_start, .blank_a(1'b0), .blank_b(1'b0),
        .low_trip_a, .low_trip_b(1'b0), .high_trip, .overtemp, .driver_disable_input, .bridge_off_a,
        .bridge_off_b, .err_flag_a, .err_flag_b, .err_flag_hs, .coil_a_entry, .coil_b_entry, .step_pulse);
    smfmc_asserts u_smfmc_asserts (.clk, .resetn, .sclk(link.sclk), .csn(link.csn), .mosi(link.mosi),
        .overtemp, .driver_disable_input, .bridge_off_a, .bridge_off_b, .step_pulse);
    // Clock and an eight-clock chopper period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        pwm_cnt <= pwm_cnt + 3'h1;
        pwm_cycle_start <= &pwm_cnt;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Bus master: each channel released at the edge that takes it
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        while (bvalid !== 1'b1) @(posedge clk);
        chk(32'(bresp), 32'(RESP_OKAY));
        bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask
    // Queue drains when the driver takes the word; bounded so a lost frame cannot hang
    task automatic send(input logic [11:0] e, input logic [31:0] cmd);
        exp_q.push_back(e);
        axi_wr(REG_CMD, cmd);
        for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge clk);
    endtask
    task automatic step_go(input logic ccw, input logic [1:0] dm);
        phase = ccw ? phase - 6'h01 : phase + 6'h01;
        w = {SINE_TABLE[phase], SINE_TABLE[phase + QUAD_OFFSET]} ^ (ccw ? DECAY_BITS_MASK : 12'h000);
        if (dm == DECAY_OFF) w = w & ~DECAY_BITS_MASK;
        if (dm == DECAY_ON) w = w | DECAY_BITS_MASK;
        send(w, {28'h0, dm, ccw, 1'b1});
    endtask
    // Every step pulse is matched to the oldest expected word
    always @(posedge clk) begin
        if (resetn && step_pulse === 1'b1) chk({coil_a_entry, coil_b_entry}, exp_q.pop_front());
    end
    task automatic final_report();
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        final_report();
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, low_trip_a, overtemp, driver_disable_input, high_trip} = '0;
        {awaddr, araddr, wdata, pwm_cnt, resetn, phase} = '0;
        wstrb = 4'hF;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        chk({err_flag_a, err_flag_b, err_flag_hs}, 3'h0);
        for (int i = 0; i < 12; i++) step_go(1'($random(seed)), 2'(i % 3));
        axi_rd(REG_STATUS);
        chk(rd[13:8], phase);
        axi_rd(8'h10);
        chk(rd, 32'h0);
        chk(32'(rr), 32'(RESP_SLVERR));
        // Held trip on bridge A: one count per chopper period, lockout at three
        low_trip_a <= 1'b1;
        repeat (5) @(posedge clk);
        chk(err_flag_a, 1'b0);
        repeat (35) @(posedge clk);
        chk({err_flag_a, err_flag_b, bridge_off_b}, 3'h4);
        low_trip_a <= 1'b0;
        repeat (300) @(posedge clk);
        chk(bridge_off_a, 1'b1);
        repeat (240) @(posedge clk);
        chk({bridge_off_a, err_flag_a}, 2'h1);
        // Zero word disables and clears; a go while the link is busy is skipped
        exp_q.push_back(12'h000);
        axi_wr(REG_CMD, 32'h11);
        axi_wr(REG_CMD, 32'h11);
        repeat (150) @(posedge clk);
        chk(err_flag_a, 1'b0);
        axi_rd(REG_SKIP);
        chk(rd, 32'h1);
        step_go(1'b0, DECAY_TABLE);
        overtemp <= 1'b1;
        repeat (10) @(posedge clk);
        chk({bridge_off_a, bridge_off_b}, 2'h3);
        axi_rd(REG_STATUS);
        chk(rd[STAT_PREWARN], 1'b1);
        overtemp <= 1'b0;
        repeat (10) @(posedge clk);
        chk({bridge_off_a, bridge_off_b}, 2'h0);
        // High-side trip stops both bridges
        high_trip <= 1'b1;
        repeat (10) @(posedge clk);
        chk({bridge_off_a, bridge_off_b}, 2'h3);
        high_trip <= 1'b0;
        driver_disable_input <= 1'b1;
        repeat (10) @(posedge clk);
        chk({bridge_off_a, bridge_off_b}, 2'h3);
        final_report();
    end
endmodule
`default_nettype wire
